/* File: bench/pcsox_partner.sv */
/* remote transceiver seen through the OAM status pins
   assumes the bank's toggle output marks each newly loaded message */
`timescale 1ns/100ps
`default_nettype none
module pcsox_partner (
	input wire logic mclk_in, // clock
	input wire logic rst_n_in, // reset, active low
	input wire logic flip_in, // toggle of the loaded message
	input wire logic ping_in, // ping value sent to us
	output logic ack_out, // acknowledge pulse
	output logic ack_flip_out, // acked toggle, valid with the pulse
	output logic ping_good_out, // good frame pulse
	output logic ping_bit_out // partner ping, valid with the pulse
);
	logic last_q;
	logic [2:0] wait_q;
	// answer each new toggle a few cycles later, as a frame would
	always_ff @(posedge mclk_in) begin
		last_q <= flip_in;
		if (!rst_n_in) wait_q <= 3'h0;
		else if (flip_in != last_q) wait_q <= 3'h4;
		else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
	end
	// outside the pulse ack_flip_out carries the inverse toggle and ping_bit_out the ping sent; during the pulse the ping comes back inverted
	assign ack_out = (wait_q == 3'h1);
	assign ping_good_out = ack_out;
	assign ack_flip_out = ack_out ? flip_in : !flip_in;
	assign ping_bit_out = ack_out ? !ping_in : ping_in;
endmodule : pcsox_partner
`default_nettype wire

/* File: bench/pcsox_regs_assertions.sv */
/* concurrent checks on the register bank ports
   assumes a bind from the bench top with RELINK_CYC of 8 */
`timescale 1ns/100ps
`default_nettype none
`include "pcsox_params.svh"
module pcsox_regs_assertions #(
	parameter int RELINK_CYC = 8,
	parameter int NUM_W = 4
) (
	input wire logic mclk_in, // clock
	input wire logic rst_n_in, // reset, active low
	input wire logic [15:0] reg_addr_in, // address
	input wire logic reg_wr_in, // write strobe
	input wire pcsox_pkg::pcsox_word_t reg_wdata_in, // write data
	input wire logic oam_load_in, // load pulse
	input wire pcsox_pkg::pcsox_snr_t local_signal_quality_in, // quality in
	input wire logic oam_frame_end_in, // frame end pulse
	input wire logic eee_enable_in, // eee mode
	input wire logic msg_out_pending_out, // valid bit
	input wire logic msg_out_flip_bit_out, // toggle
	input wire logic [NUM_W-1:0] msg_out_number_out, // number
	input wire pcsox_pkg::pcsox_word_t msg_out_octets_1_0_out, // octets 1/0
	input wire pcsox_pkg::pcsox_snr_t tx_signal_quality_out, // quality out
	input wire logic lpi_exit_request_out, // idle exit
	input wire logic link_drop_out // link drop
);
	import pcsox_pkg::*;
	logic take;
	logic set_sw;
	logic lpi_cause;
	// a load only counts while a message waits; software set wins over it
	assign take = msg_out_pending_out && oam_load_in;
	assign set_sw = reg_wr_in && ((reg_addr_in & 16'h0FFF) == 16'h0904) && reg_wdata_in[15];
	assign lpi_cause = eee_enable_in && (local_signal_quality_in == 2'h1);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	AST_LOAD_CLEARS:
	assert property (take && !set_sw |=> !msg_out_pending_out) else $error("valid stayed");
	AST_PENDING_SET:
	assert property (set_sw |=> msg_out_pending_out) else $error("valid not set");
	AST_FLIP_INVERTS:
	assert property (take |=> msg_out_flip_bit_out != $past(msg_out_flip_bit_out))
		else $error("toggle not inverted");
	AST_FLIP_HW_ONLY:
	assert property (!take |=> $stable(msg_out_flip_bit_out)) else $error("toggle moved");
	AST_NUM_HOLDS:
	assert property (!take |=> $stable(msg_out_number_out)) else $error("number moved");
	AST_OCTETS_HOLD:
	assert property (!take |=> $stable(msg_out_octets_1_0_out)) else $error("octets moved");
	AST_QUALITY_FOLLOWS:
	assert property (1'b1 |=> tx_signal_quality_out == $past(local_signal_quality_in))
		else $error("quality code wrong");
	AST_LPI_REQUEST:
	assert property (1'b1 |=> lpi_exit_request_out == $past(lpi_cause)) else $error("lpi wrong");
	AST_DROP_LENGTH:
	assert property ($rose(link_drop_out) |-> link_drop_out [*8] ##1 !link_drop_out)
		else $error("drop length wrong");
	AST_DROP_AFTER_END:
	assert property ($rose(link_drop_out) |-> $past(oam_frame_end_in)) else $error("early drop");
	cover property (take);
	cover property ($rose(link_drop_out));
	cover property (lpi_exit_request_out);
endmodule : pcsox_regs_assertions
`default_nettype wire

/* File: bench/test_pcs_status_oam_tx_regs.sv */
/* self-checking bench for the status and OAM transmit register bank
   assumes the partner model and the checker are compiled before it */
`timescale 1ns/100ps
`default_nettype none
module test_pcs_status_oam_tx_regs;
	import pcsox_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, load = 1'b0, fend = 1'b0;
	logic eee = 1'b0, fault = 1'b0, link = 1'b0, hier = 1'b0, lock = 1'b0, p;
	logic [15:0] addr = 16'h0000;
	pcsox_word_t wdata = 16'h0000, rdata, o10, o32, o54, o76;
	pcsox_word_t exp_q[$];
	pcsox_word_t w[4];
	pcsox_snr_t q = 2'h3, tq;
	logic rv, pend, flip, ping_o, lpi, drop, ack, ackf, pg, pb;
	logic [3:0] num, num_o;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	pcsox_regs #(.RELINK_CYC(8), .NUM_W(4)) DUT (.mclk_in(clk), .rst_n_in(rst_n),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_rvalid_out(rv), .pcs_fault_in(fault), .rx_link_up_in(link),
		.high_error_rate_live_in(hier), .block_lock_in(lock), .oam_load_in(load),
		.partner_ack_in(ack), .partner_ack_flip_in(ackf), .ping_good_in(pg),
		.ping_frame_bit_in(pb), .local_signal_quality_in(q), .oam_frame_end_in(fend),
		.eee_enable_in(eee), .msg_out_pending_out(pend), .msg_out_flip_bit_out(flip),
		.msg_out_number_out(num_o), .ping_out_value_out(ping_o), .msg_out_octets_1_0_out(o10),
		.msg_out_octets_3_2_out(o32), .msg_out_octets_5_4_out(o54), .msg_out_octets_7_6_out(o76),
		.tx_signal_quality_out(tq), .lpi_exit_request_out(lpi), .link_drop_out(drop));
	pcsox_partner u_partner (.mclk_in(clk), .rst_n_in(rst_n), .flip_in(flip), .ping_in(ping_o),
		.ack_out(ack), .ack_flip_out(ackf), .ping_good_out(pg), .ping_bit_out(pb));
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic rd_w(input logic [15:0] a, input logic [15:0] e);
		addr = a;
		rd = 1'b1;
		exp_q.push_back(e);
		tick(1);
		rd = 1'b0;
		tick(1);
	endtask : rd_w
	task automatic wr_w(input logic [15:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask : wr_w
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	// free-running clock
	initial forever #10 clk = ~clk;
	// read answers are taken off the note queue mid-cycle, where they are settled
	always @(negedge clk) begin
		if (rv === 1'b1) begin
			if (exp_q.size() == 0) chk(rdata, ~rdata);
			else chk(rdata, exp_q.pop_front());
		end
	end
	// hang guard, well above the expected run of some 120 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		void'($urandom(31));
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		tick(1);
		// reset words, the unmapped one among them
		for (int a = 16'h3901; a <= 16'h3908; a++)
			rd_w(a[15:0], (a == 16'h3904) ? 16'h0003 : 16'h0000);
		fault = 1'b1;
		link = 1'b1;
		hier = 1'b1;
		lock = 1'b1;
		tick(2);
		rd_w(16'h3901, 16'h0080);
		rd_w(16'h0901, 16'h0084);
		rd_w(16'h3902, 16'h0780);
		// a one-cycle loss of lock must still be seen
		lock = 1'b0;
		hier = 1'b0;
		tick(1);
		lock = 1'b1;
		tick(2);
		rd_w(16'h3902, 16'h0580);
		rd_w(16'h3902, 16'h0540);
		for (int i = 0; i < 2; i++) begin
			foreach (w[k]) begin
				w[k] = 16'($urandom());
				wr_w(16'h3905 + 16'(k), w[k]);
			end
			num = 4'($urandom());
			p = 1'($urandom());
			// read-only bits written as ones to show they are ignored
			wr_w(16'h3904, {4'hF, num, 4'hF, 1'b1, p, 2'h0});
			chk(pend, 1'b1);
			chk(ping_o, p);
			load = 1'b1;
			tick(1);
			load = 1'b0;
			chk({pend, flip, num_o}, {1'b0, !i[0], num});
			chk(o10, w[0]);
			chk(o32, w[1]);
			chk(o54, w[2]);
			chk(o76, w[3]);
			tick(8);
			rd_w(16'h3904, {1'b0, !i[0], 1'b1, !i[0], num, 4'h0, !p, p, 2'h3});
			rd_w(16'h3904, {1'b0, !i[0], 1'b0, !i[0], num, 4'h0, !p, p, 2'h3});
			load = 1'b1;
			tick(1);
			load = 1'b0;
			chk({pend, flip}, {1'b0, !i[0]});
		end
		eee = 1'b1;
		for (int i = 3; i >= 0; i--) begin
			q = 2'(i);
			tick(2);
			chk(tq, q);
			chk(lpi, i == 1);
		end
		fend = 1'b1;
		tick(1);
		fend = 1'b0;
		q = 2'h1;
		eee = 1'b0;
		chk(drop, 1'b1);
		tick(7);
		chk({drop, lpi}, 2'b10);
		tick(1);
		chk(drop, 1'b0);
		tick(4);
		conclude();
	end
endmodule : test_pcs_status_oam_tx_regs
bind pcsox_regs pcsox_regs_assertions #(.RELINK_CYC(RELINK_CYC), .NUM_W(NUM_W)) u_chk (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
	.reg_wdata_in(reg_wdata_in), .oam_load_in(oam_load_in),
	.local_signal_quality_in(local_signal_quality_in), .oam_frame_end_in(oam_frame_end_in),
	.eee_enable_in(eee_enable_in), .msg_out_pending_out(msg_out_pending_out),
	.msg_out_flip_bit_out(msg_out_flip_bit_out), .msg_out_number_out(msg_out_number_out),
	.msg_out_octets_1_0_out(msg_out_octets_1_0_out), .tx_signal_quality_out(tx_signal_quality_out),
	.lpi_exit_request_out(lpi_exit_request_out), .link_drop_out(link_drop_out));
`default_nettype wire

/* File: src/pcsox_oam_tx_ctl.sv */
/*
 * OAM transmit handshake leaf: valid/toggle bits, partner acknowledgement,
 * received ping capture and the relink sequence on a failing quality code.
 * Assumes pulses on the carrier last one clock and that frame_end marks the
 * last cycle of an outgoing frame.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pcsox_params.svh"

module pcsox_oam_tx_ctl #(
	parameter int RELINK_CYC = `PCSOX_RELINK_MIN_CYC
) (
	input wire logic mclk_in,     // device clock
	input wire logic rst_n_in,    // synchronous reset, active low
	pcsox_tx_if.ctl tx            // carrier to the register bank
);
	import pcsox_pkg::*;

	localparam int CNT_W = $clog2(RELINK_CYC + 1);

	// refuse a drop time below one cycle or above the permitted window maximum
	if (RELINK_CYC < 1 || RELINK_CYC > `PCSOX_RELINK_MAX_CYC) begin : g_chk
		$error("relink count outside the permitted window");
	end

	pcsox_relink_e state_q;
	logic [CNT_W-1:0] cnt_q;
	logic take;

	////////////////////////////////////////////////////////////////////////
	// valid and toggle handshake

	// a load only counts while a message is actually pending
	assign take = tx.load & tx.pending;

	// clear on load
	// a software set in the same cycle wins, so a fresh message is kept
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx.pending <= 1'b0;
		end else if (tx.pending_set) begin
			tx.pending <= 1'b1;
		end else if (take) begin
			tx.pending <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx.flip <= 1'b0;
		end else if (take) begin
			tx.flip <= ~tx.flip;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// partner acknowledgement and ping

	// sticky, clear on read
	// a new acknowledgement beats the read that would clear it
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx.acked <= 1'b0;
		end else if (tx.partner_ack) begin
			tx.acked <= 1'b1;
		end else if (tx.ack_read) begin
			tx.acked <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx.ack_flip <= 1'b0;
		end else if (tx.partner_ack) begin
			tx.ack_flip <= tx.partner_flip;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx.ping_in <= 1'b0;
		end else if (tx.ping_good) begin
			tx.ping_in <= tx.ping_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// relink sequence

	// drop after frame end
	// the drop lasts the minimum window, so relink lands inside 2 to 4 ms
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			state_q <= RL_IDLE;
			cnt_q <= '0;
		end else begin
			unique case (state_q)
				RL_IDLE: begin
					if (tx.snr == `PCSOX_SNR_FAILING) begin
						state_q <= tx.frame_end ? RL_DROP : RL_WAIT_FRAME;
					end
					cnt_q <= '0;
				end
				RL_WAIT_FRAME: begin
					if (tx.frame_end) begin
						state_q <= RL_DROP;
					end
				end
				RL_DROP: begin
					if (cnt_q == CNT_W'(RELINK_CYC - 1)) begin
						state_q <= RL_IDLE;
					end
					cnt_q <= cnt_q + 1'b1;
				end
			endcase
		end
	end

	assign tx.link_drop = (state_q == RL_DROP);
endmodule : pcsox_oam_tx_ctl

`default_nettype wire

/* File: src/pcsox_params.svh */
/*
 * Constants for the coding-sublayer status and OAM transmit register bank:
 * register offsets, field positions, codes and timing figures.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef PCSOX_PARAMS_SVH
`define PCSOX_PARAMS_SVH

// register offsets as printed; the top nibble selects the MMD space
`define PCSOX_ADDR_MASK 16'h0FFF
`define PCSOX_OFS_STATUS 16'h3901
`define PCSOX_OFS_STATUS_TWO 16'h3902
`define PCSOX_OFS_TX_CONTROL 16'h3904
`define PCSOX_OFS_PAYLOAD_LOW 16'h3905
`define PCSOX_OFS_PAYLOAD_MID 16'h3906
`define PCSOX_OFS_PAYLOAD_HIGH 16'h3907
`define PCSOX_OFS_PAYLOAD_TOP 16'h3908
`define PCSOX_WORD_RESET 16'h0000

// first status register fields
`define PCSOX_BIT_FAULT 7
`define PCSOX_BIT_LINK_LL 2
// second status register fields
`define PCSOX_BIT_LINK_LIVE 10
`define PCSOX_BIT_HIGH_ERR 9
`define PCSOX_BIT_BLOCK_LOCK 8
`define PCSOX_BIT_HIGH_ERR_LH 7
`define PCSOX_BIT_BLOCK_LL 6
// transmit control register fields
`define PCSOX_BIT_PENDING 15
`define PCSOX_BIT_FLIP 14
`define PCSOX_BIT_ACKED 13
`define PCSOX_BIT_ACK_FLIP 12
`define PCSOX_NUM_HI 11
`define PCSOX_NUM_LO 8
`define PCSOX_BIT_PING_IN 3
`define PCSOX_BIT_PING_OUT 2
`define PCSOX_SNR_HI 1
`define PCSOX_SNR_LO 0

// signal quality codes
`define PCSOX_SNR_FAILING 2'h0
`define PCSOX_SNR_LPI_REFRESH 2'h1
`define PCSOX_SNR_MARGINAL 2'h2
`define PCSOX_SNR_GOOD 2'h3

// timing: clock period and relink window, both in ns
`define PCSOX_CLK_NS 20
`define PCSOX_RELINK_MIN_NS 2000000
`define PCSOX_RELINK_MAX_NS 4000000
`define PCSOX_RELINK_MIN_CYC ((`PCSOX_RELINK_MIN_NS + `PCSOX_CLK_NS - 1) / `PCSOX_CLK_NS)
`define PCSOX_RELINK_MAX_CYC (`PCSOX_RELINK_MAX_NS / `PCSOX_CLK_NS)

`endif

/* File: src/pcsox_pkg.sv */
/*
 * Types shared by the register bank and its OAM transmit control leaf.
 * Assumes the params header sits beside it on the include path.
 */
`include "pcsox_params.svh"

package pcsox_pkg;
	// one management word
	typedef logic [15:0] pcsox_word_t;
	// signal quality code
	typedef logic [1:0] pcsox_snr_t;
	// relink sequencing after a failing signal quality report
	typedef enum logic [1:0] {
		RL_IDLE,
		RL_WAIT_FRAME,
		RL_DROP
	} pcsox_relink_e;
endpackage : pcsox_pkg

/* File: src/pcsox_regs.sv */
/*
 * Coding-sublayer status and OAM transmit register bank of a single-pair
 * gigabit transceiver, reached over the MMD management register space.
 * Assumes the management port gives one-cycle read and write strobes with a
 * stable address, and that all status inputs are synchronous to mclk_in.
 */
// Notes on behaviour
// - fault flag in first status bit 7
// - link up live bit 10, latched bit 2
// - high error rate live in bit 9
// - block lock live in bit 8
// - high error rate latched high, bit 7
// - block lock latched low, bit 6
// - valid self-clears when message is loaded
// - toggle bit 14 set by hardware only
// - partner acknowledge bit 13, clear on read
// - bit 12 shows acknowledged toggle value
// - message number bits 11-8 sent along
// - bit 3 holds latest received ping
// - bit 2 ping value sent out
// - bits 1-0 report local signal quality
// - failing quality drops link then relinks
// - code 01 asks partner leave idle
// - octets 1/0 and 3/2, lsb first
// - octets 5/4 and 7/6, lsb first
`timescale 1ns/100ps
`default_nettype none
`include "pcsox_params.svh"

module pcsox_regs #(
	parameter int RELINK_CYC = `PCSOX_RELINK_MIN_CYC,
	parameter int NUM_W = 4
) (
	input wire logic mclk_in,                          // device clock, 50 MHz
	input wire logic rst_n_in,                         // synchronous reset, active low
	input wire logic [15:0] reg_addr_in,               // management register address
	input wire logic reg_wr_in,                        // write strobe, one cycle
	input wire logic reg_rd_in,                        // read strobe, one cycle
	input wire pcsox_pkg::pcsox_word_t reg_wdata_in,   // write data
	output pcsox_pkg::pcsox_word_t reg_rdata_out,      // read data, registered
	output logic reg_rvalid_out,                       // read data valid pulse
	input wire logic pcs_fault_in,                     // fault condition present
	input wire logic rx_link_up_in,                    // receive link up
	input wire logic high_error_rate_live_in,          // high error rate reported
	input wire logic block_lock_in,                    // locked to received blocks
	input wire logic oam_load_in,                      // state machine takes message
	input wire logic partner_ack_in,                   // partner acknowledged, pulse
	input wire logic partner_ack_flip_in,              // toggle acknowledged
	input wire logic ping_good_in,                     // good frame received, pulse
	input wire logic ping_frame_bit_in,                // ping value in that frame
	input wire pcsox_pkg::pcsox_snr_t local_signal_quality_in, // local quality code
	input wire logic oam_frame_end_in,                 // end of outgoing frame
	input wire logic eee_enable_in,                    // energy-efficient mode on
	output logic msg_out_pending_out,                  // message waiting to be taken
	output logic msg_out_flip_bit_out,                 // toggle for the message
	output logic [NUM_W-1:0] msg_out_number_out,       // number sent with message
	output logic ping_out_value_out,                   // ping sent in every frame
	output pcsox_pkg::pcsox_word_t msg_out_octets_1_0_out, // loaded octets 1/0
	output pcsox_pkg::pcsox_word_t msg_out_octets_3_2_out, // loaded octets 3/2
	output pcsox_pkg::pcsox_word_t msg_out_octets_5_4_out, // loaded octets 5/4
	output pcsox_pkg::pcsox_word_t msg_out_octets_7_6_out, // loaded octets 7/6
	output pcsox_pkg::pcsox_snr_t tx_signal_quality_out,   // quality code sent out
	output logic lpi_exit_request_out,                 // ask partner to leave idle
	output logic link_drop_out                         // hold link down before relink
);
	import pcsox_pkg::*;

	// the number field is four bits wide in the control word
	if (NUM_W != (`PCSOX_NUM_HI - `PCSOX_NUM_LO + 1)) begin : g_chk
		$error("message number width must match the control field");
	end

	pcsox_tx_if tx ();

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic sel_status;
	logic sel_status_two;
	logic sel_tx_control;
	logic sel_pay_low;
	logic sel_pay_mid;
	logic sel_pay_high;
	logic sel_pay_top;
	logic mapped;
	logic [15:0] addr_low;

	// the MMD nibble on top of the address is ignored
	assign addr_low = reg_addr_in & `PCSOX_ADDR_MASK;
	assign sel_status = (addr_low == (`PCSOX_OFS_STATUS & `PCSOX_ADDR_MASK));
	assign sel_status_two = (addr_low == (`PCSOX_OFS_STATUS_TWO & `PCSOX_ADDR_MASK));
	assign sel_tx_control = (addr_low == (`PCSOX_OFS_TX_CONTROL & `PCSOX_ADDR_MASK));
	assign sel_pay_low = (addr_low == (`PCSOX_OFS_PAYLOAD_LOW & `PCSOX_ADDR_MASK));
	assign sel_pay_mid = (addr_low == (`PCSOX_OFS_PAYLOAD_MID & `PCSOX_ADDR_MASK));
	assign sel_pay_high = (addr_low == (`PCSOX_OFS_PAYLOAD_HIGH & `PCSOX_ADDR_MASK));
	assign sel_pay_top = (addr_low == (`PCSOX_OFS_PAYLOAD_TOP & `PCSOX_ADDR_MASK));
	assign mapped = sel_status | sel_status_two | sel_tx_control | sel_pay_low |
		sel_pay_mid | sel_pay_high | sel_pay_top;

	// software access to each latched word; a write of zero counts too
	logic status_access;
	logic status_two_access;
	logic link_refresh;
	logic high_err_refresh;
	logic block_refresh;

	assign status_access = sel_status & (reg_rd_in | reg_wr_in);
	assign status_two_access = sel_status_two & (reg_rd_in | reg_wr_in);
	assign link_refresh = status_access &
		(reg_rd_in | ~reg_wdata_in[`PCSOX_BIT_LINK_LL]);
	assign high_err_refresh = status_two_access &
		(reg_rd_in | ~reg_wdata_in[`PCSOX_BIT_HIGH_ERR_LH]);
	assign block_refresh = status_two_access &
		(reg_rd_in | ~reg_wdata_in[`PCSOX_BIT_BLOCK_LL]);

	////////////////////////////////////////////////////////////////////////
	// live status sampling

	logic fault_q;
	logic link_live_q;
	logic high_err_q;
	logic block_lock_q;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			fault_q <= 1'b0;
			link_live_q <= 1'b0;
			high_err_q <= 1'b0;
			block_lock_q <= 1'b0;
		end else begin
			fault_q <= pcs_fault_in;
			link_live_q <= rx_link_up_in;
			high_err_q <= high_error_rate_live_in;
			block_lock_q <= block_lock_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// latched status flags

	logic rx_link_latched_low_q;
	logic high_error_rate_latched_q;
	logic rx_block_aligned_latched_q;

	// link latched low
	// a drop wins over the refresh; a read reloads the live level
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_link_latched_low_q <= 1'b0;
		end else if (!rx_link_up_in) begin
			rx_link_latched_low_q <= 1'b0;
		end else if (link_refresh) begin
			rx_link_latched_low_q <= 1'b1;
		end
	end

	// latched high error
	// an error report in the access cycle keeps the flag set
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			high_error_rate_latched_q <= 1'b0;
		end else if (high_error_rate_live_in) begin
			high_error_rate_latched_q <= 1'b1;
		end else if (high_err_refresh) begin
			high_error_rate_latched_q <= 1'b0;
		end
	end

	// block lock latched low
	// starts at zero, so software must read once to see lock held
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_block_aligned_latched_q <= 1'b0;
		end else if (!block_lock_in) begin
			rx_block_aligned_latched_q <= 1'b0;
		end else if (block_refresh) begin
			rx_block_aligned_latched_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable transmit fields

	logic [NUM_W-1:0] msg_out_number_q;
	logic ping_out_value_q;
	pcsox_word_t payload_q [4];
	logic [3:0] pay_sel;

	assign pay_sel = {sel_pay_top, sel_pay_high, sel_pay_mid, sel_pay_low};

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			msg_out_number_q <= '0;
			ping_out_value_q <= 1'b0;
		end else if (reg_wr_in && sel_tx_control) begin
			msg_out_number_q <= reg_wdata_in[`PCSOX_NUM_HI:`PCSOX_NUM_LO];
			ping_out_value_q <= reg_wdata_in[`PCSOX_BIT_PING_OUT];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pay
			always_ff @(posedge mclk_in) begin
				if (!rst_n_in) begin
					payload_q[gi] <= `PCSOX_WORD_RESET;
				end else if (reg_wr_in && pay_sel[gi]) begin
					payload_q[gi] <= reg_wdata_in;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// handshake with the transmit control leaf

	// set only after content
	// writing the valid bit in the same word as the number is allowed;
	// the number lands in the same edge as the valid bit
	assign tx.pending_set = reg_wr_in & sel_tx_control & reg_wdata_in[`PCSOX_BIT_PENDING];
	assign tx.ack_read = reg_rd_in & sel_tx_control;
	assign tx.load = oam_load_in;
	assign tx.partner_ack = partner_ack_in;
	assign tx.partner_flip = partner_ack_flip_in;
	assign tx.ping_good = ping_good_in;
	assign tx.ping_bit = ping_frame_bit_in;
	assign tx.frame_end = oam_frame_end_in;
	assign tx.snr = local_signal_quality_in;

	pcsox_oam_tx_ctl #(
		.RELINK_CYC(RELINK_CYC)
	) u_tx_ctl (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.tx(tx.ctl)
	);

	////////////////////////////////////////////////////////////////////////
	// loaded message snapshot

	// number and all four octet words on load
	// snapshot at load so later software writes cannot tear a message;
	// bit 0 of each word is the first bit on the wire
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			msg_out_number_out <= '0;
			msg_out_octets_1_0_out <= `PCSOX_WORD_RESET;
			msg_out_octets_3_2_out <= `PCSOX_WORD_RESET;
			msg_out_octets_5_4_out <= `PCSOX_WORD_RESET;
			msg_out_octets_7_6_out <= `PCSOX_WORD_RESET;
		end else if (oam_load_in && tx.pending) begin
			msg_out_number_out <= msg_out_number_q;
			msg_out_octets_1_0_out <= payload_q[0];
			msg_out_octets_3_2_out <= payload_q[1];
			msg_out_octets_5_4_out <= payload_q[2];
			msg_out_octets_7_6_out <= payload_q[3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outgoing quality and idle control

	// leave idle request
	// only meaningful with energy-efficient mode on
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx_signal_quality_out <= `PCSOX_SNR_FAILING;
			lpi_exit_request_out <= 1'b0;
		end else begin
			tx_signal_quality_out <= local_signal_quality_in;
			lpi_exit_request_out <= eee_enable_in &
				(local_signal_quality_in == `PCSOX_SNR_LPI_REFRESH);
		end
	end

	// leaf state straight out, plus the bank's ping value; pending and toggle are leaf flip-flops, link drop decodes the leaf state
	assign msg_out_pending_out = tx.pending;
	assign msg_out_flip_bit_out = tx.flip;
	assign link_drop_out = tx.link_drop;
	assign ping_out_value_out = ping_out_value_q;

	////////////////////////////////////////////////////////////////////////
	// read data assembly

	pcsox_word_t rd_mux;

	always_comb begin
		rd_mux = `PCSOX_WORD_RESET;
		if (sel_status) begin
			rd_mux[`PCSOX_BIT_FAULT] = fault_q;
			rd_mux[`PCSOX_BIT_LINK_LL] = rx_link_latched_low_q;
		end else if (sel_status_two) begin
			rd_mux[`PCSOX_BIT_LINK_LIVE] = link_live_q;
			rd_mux[`PCSOX_BIT_HIGH_ERR] = high_err_q;
			rd_mux[`PCSOX_BIT_BLOCK_LOCK] = block_lock_q;
			rd_mux[`PCSOX_BIT_HIGH_ERR_LH] = high_error_rate_latched_q;
			rd_mux[`PCSOX_BIT_BLOCK_LL] = rx_block_aligned_latched_q;
		end else if (sel_tx_control) begin
			rd_mux[`PCSOX_BIT_PENDING] = tx.pending;
			rd_mux[`PCSOX_BIT_FLIP] = tx.flip;
			rd_mux[`PCSOX_BIT_ACKED] = tx.acked;
			rd_mux[`PCSOX_BIT_ACK_FLIP] = tx.ack_flip;
			rd_mux[`PCSOX_NUM_HI:`PCSOX_NUM_LO] = msg_out_number_q;
			rd_mux[`PCSOX_BIT_PING_IN] = tx.ping_in;
			rd_mux[`PCSOX_BIT_PING_OUT] = ping_out_value_q;
			rd_mux[`PCSOX_SNR_HI:`PCSOX_SNR_LO] = local_signal_quality_in;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (pay_sel[i]) begin
					rd_mux = payload_q[i];
				end
			end
		end
	end

	// data is captured with the strobe, so latched flags show the value
	// from before the read refreshes them
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= `PCSOX_WORD_RESET;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= mapped ? rd_mux : `PCSOX_WORD_RESET;
			end
		end
	end
endmodule : pcsox_regs

`default_nettype wire

/* File: src/pcsox_tx_if.sv */
/*
 * Carrier between the register bank and the OAM transmit control leaf.
 * Assumes both ends run on the same clock; all signals are levels or
 * single-cycle pulses in that domain.
 */
`timescale 1ns/100ps
`default_nettype none

interface pcsox_tx_if;
	import pcsox_pkg::*;
	logic load;          // state machine takes the pending message
	logic pending_set;   // software wrote a one to the valid bit
	logic ack_read;      // software read the transmit control word
	logic partner_ack;   // partner acknowledged a message
	logic partner_flip;  // toggle value acknowledged by the partner
	logic ping_good;     // good frame received
	logic ping_bit;      // ping value in that frame
	logic frame_end;     // end of the current outgoing frame
	pcsox_snr_t snr;     // local signal quality
	logic pending;       // message waiting to be taken
	logic flip;          // toggle to send with the message
	logic acked;         // sticky partner acknowledgement
	logic ack_flip;      // last acknowledged toggle
	logic ping_in;       // captured ping value
	logic link_drop;     // link held down before relink
	modport bank (output load, pending_set, ack_read, partner_ack, partner_flip,
		ping_good, ping_bit, frame_end, snr,
		input pending, flip, acked, ack_flip, ping_in, link_drop);
	modport ctl (input load, pending_set, ack_read, partner_ack, partner_flip,
		ping_good, ping_bit, frame_end, snr,
		output pending, flip, acked, ack_flip, ping_in, link_drop);
endinterface : pcsox_tx_if

`default_nettype wire
